// >>> shared/wdtl_pkg.sv
`default_nettype none
package wdtl_pkg;

    // Reference clock period and derived reset hold time
    localparam int unsigned CLK_PERIOD_NS   = 4;
    localparam int unsigned POR_TIME_US     = 5000;
    localparam int unsigned POR_CYCLES      = (POR_TIME_US * 1000) / CLK_PERIOD_NS;

    // Write window: 60 processor cycles, counted as crystal clocks
    localparam int unsigned WIN_CPU_CYCLES  = 60;
    localparam logic [6:0]  WIN_XTAL_TICKS  = 7'h7a;

    // Register location in the expanded bank
    localparam logic [3:0]  MODE_BANK       = 4'hf;
    localparam logic [7:0]  MODE_OFFSET     = 8'h0f;
    localparam logic [7:0]  STATUS_OFFSET   = 8'h0e;

    // Mode field positions
    localparam int unsigned TAP_LSB         = 0;
    localparam int unsigned HALT_BIT        = 2;
    localparam int unsigned STOP_BIT        = 3;
    localparam int unsigned CLKSEL_BIT      = 4;

    // Mode reset values
    localparam logic [1:0]  TAP_RST         = 2'h1;
    localparam logic        HALT_RST        = 1'b1;
    localparam logic        STOP_RST        = 1'b1;
    localparam logic        CLKSEL_RST      = 1'b0;

    // Terminal counts minus one, per tap code
    localparam logic [11:0] TERM_M1_256     = 12'h0ff;
    localparam logic [11:0] TERM_M1_512     = 12'h1ff;
    localparam logic [11:0] TERM_M1_1024    = 12'h3ff;
    localparam logic [11:0] TERM_M1_4096    = 12'hfff;

    // Restart address after a stop-mode timeout
    localparam logic [15:0] RESTART_VECTOR  = 16'h000c;
    // Zero, sign, overflow after the refresh instruction
    localparam logic [2:0]  FLAG_ZSV_VALUE  = 3'h4;

    // Mode register image, bit 4 down to bit 0
    typedef struct packed {
        logic       clk_xtal;
        logic       stop_run;
        logic       halt_run;
        logic [1:0] tap;
    } wdtl_mode_t;

    localparam wdtl_mode_t MODE_RST = '{CLKSEL_RST, STOP_RST, HALT_RST, TAP_RST};

    // Register port request
    typedef struct packed {
        logic [3:0] bank;
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } wdtl_req_t;

    // Watchdog states, Gray along idle, run, hold
    typedef enum logic [1:0] {
        WDTL_IDLE = 2'b00,
        WDTL_RUN  = 2'b01,
        WDTL_HOLD = 2'b11
    } wdtl_state_t;

endpackage : wdtl_pkg
`default_nettype wire

// >>> design/wdtl_watchdog.sv
`timescale 1ns/10ps
`default_nettype none

//Contract
//(R01) Retriggerable counter resets processor at terminal count
//(R02) Idle until first instruction; later ones restart
//(R03) Refresh instruction updates zero, sign, overflow flags
//(R04) Mode writes only in 122-clock window after reset
//(R05) Mode register is write-only, reads return zero
//(R06) Mode register sits at bank F, 0x0f
//(R07) Tap code selects 256/512/1024/4096 count
//(R08) Tap resets to code 01
//(R09) Bit 2 keeps counting in halt, default 1
//(R10) Bit 3 keeps counting in stop, default 1
//(R11) Software picks RC clock for stop operation
//(R12) Bit 4 selects crystal pin, default RC
//(R13) Bits 5 to 7 are ignored
//(R14) Timeout holds processor reset for 5 ms
//(R15) Stop-mode timeout restarts at address 0x000c
//(R16) Reset disarms counter, mode returns to defaults; stop_recovery defaults mode, counter stays armed
module wdtl_watchdog
    import wdtl_pkg::*;
#(
    parameter int unsigned POR_HOLD_CYCLES = POR_CYCLES
)(
    input  wire logic        ref_clk,
    input  wire logic        rst,
    input  wire wdtl_req_t   bus_req,
    output logic      [7:0]  rd_data,
    input  wire logic        wdt_instr,
    input  wire logic        first_instr,
    input  wire logic        halt_mode,
    input  wire logic        stop_mode,
    input  wire logic        stop_recovery,
    input  wire logic        crystal_input_pin,
    input  wire logic        rc_osc_pin,
    output logic             proc_reset,
    output logic             stop_exit,
    output logic     [15:0]  restart_addr,
    output logic             flag_we,
    output logic      [2:0]  flag_zsv
);

    // Oscillator synchronisers: bit 1 crystal, bit 0 RC
    logic [1:0]  osc_meta_reg;
    logic [1:0]  osc_sync_reg;
    logic [1:0]  osc_prev_reg;
    // Watchdog state and counters
    wdtl_state_t state_reg;
    wdtl_state_t state_next;
    logic [11:0] count_reg;
    logic [11:0] count_next;
    logic [20:0] hold_cnt_reg;
    logic [20:0] hold_cnt_next;
    // Mode register and write window
    wdtl_mode_t  mode_reg;
    logic        win_wait_reg;
    logic        win_open_reg;
    logic [6:0]  win_cnt_reg;
    // Registered outputs
    logic [7:0]  rd_data_reg;
    logic        stop_exit_reg;
    logic [15:0] restart_addr_reg;
    logic        flag_we_reg;
    logic [2:0]  flag_zsv_reg;

    // Decoded events
    wire logic [1:0]  osc_tick;
    wire logic        xtal_tick;
    wire logic        rc_tick;
    wire logic        cnt_tick;
    wire logic        run_ok;
    wire logic [11:0] term_m1;
    wire logic        at_term;
    wire logic        timeout;
    wire logic        hold_done;
    wire logic        rearm;
    wire logic        in_bank;
    wire logic        hit_mode;
    wire logic        hit_status;
    wire logic        mode_wr;
    wire logic        win_last;
    wire logic [7:0]  status_word;

    // Rising edges of the synchronised oscillator pins
    assign osc_tick  = osc_sync_reg & ~osc_prev_reg;
    assign xtal_tick = osc_tick[1];
    assign rc_tick   = osc_tick[0];

    // Counter clock source; crystal edges cease in stop mode [R11]
    assign cnt_tick = mode_reg.clk_xtal ? xtal_tick : rc_tick; // [R12]

    // Suspend in halt or stop unless the mode bit keeps it running
    assign run_ok = ~(halt_mode & ~mode_reg.halt_run) // [R09]
                  & ~(stop_mode & ~mode_reg.stop_run); // [R10]

    // Terminal count per tap code
    assign term_m1 = (mode_reg.tap == 2'h0) ? TERM_M1_256  // [R07]
                   : (mode_reg.tap == 2'h1) ? TERM_M1_512
                   : (mode_reg.tap == 2'h2) ? TERM_M1_1024
                   : TERM_M1_4096;

    // Refresh in the same cycle beats the terminal count
    assign at_term   = (count_reg == term_m1);
    assign timeout   = (state_reg == WDTL_RUN) & cnt_tick & run_ok
                     & at_term & ~wdt_instr; // [R01]
    assign hold_done = (hold_cnt_reg == 21'(POR_HOLD_CYCLES - 1));

    // Any reset apart from the asynchronous one re-arms the window to wait for the first instruction
    assign rearm = ((state_reg == WDTL_HOLD) & hold_done) | stop_recovery;

    // Register decode
    assign in_bank    = (bus_req.bank == MODE_BANK);
    assign hit_mode   = in_bank & (bus_req.addr == MODE_OFFSET); // [R06]
    assign hit_status = in_bank & (bus_req.addr == STATUS_OFFSET);
    assign mode_wr    = bus_req.wr & hit_mode & win_open_reg; // [R04]
    assign win_last   = xtal_tick & (win_cnt_reg == WIN_XTAL_TICKS - 7'h01);

    // Status word: observable block state, read only
    assign status_word = {3'h0, mode_reg.clk_xtal,
                          proc_reset, win_wait_reg,
                          win_open_reg, (state_reg != WDTL_IDLE)};

    // Two flip-flops before any logic sees the oscillator pins
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            osc_meta_reg <= 2'h0;
            osc_sync_reg <= 2'h0;
            osc_prev_reg <= 2'h0;
        end
        else
        begin
            osc_meta_reg <= {crystal_input_pin, rc_osc_pin};
            osc_sync_reg <= osc_meta_reg;
            osc_prev_reg <= osc_sync_reg;
        end
    end

    // Next state of the watchdog counter
    always_comb
    begin
        state_next    = state_reg;
        count_next    = count_reg;
        hold_cnt_next = hold_cnt_reg;
        case (state_reg)
            WDTL_IDLE:
            begin
                // Disarmed until the first refresh instruction
                if (wdt_instr)
                begin
                    state_next = WDTL_RUN; // [R02]
                    count_next = 12'h000;
                end
            end
            WDTL_RUN:
            begin
                if (wdt_instr)
                begin
                    count_next = 12'h000; // [R02]
                end
                else if (timeout)
                begin
                    // Start the reset one-shot
                    state_next    = WDTL_HOLD; // [R14]
                    count_next    = 12'h000;
                    hold_cnt_next = 21'h000000;
                end
                else if (cnt_tick & run_ok)
                begin
                    count_next = count_reg + 12'h001; // [R01]
                end
            end
            WDTL_HOLD:
            begin
                // Refresh is meaningless while the processor is held
                if (hold_done)
                begin
                    state_next = WDTL_IDLE; // [R16]
                end
                else
                begin
                    hold_cnt_next = hold_cnt_reg + 21'h000001; // [R14]
                end
            end
            default:
            begin
                state_next = WDTL_IDLE;
            end
        endcase
    end

    // Watchdog state registers
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            state_reg    <= WDTL_IDLE; // [R16]
            count_reg    <= 12'h000;
            hold_cnt_reg <= 21'h000000;
        end
        else
        begin
            state_reg    <= state_next;
            count_reg    <= count_next;
            hold_cnt_reg <= hold_cnt_next;
        end
    end

    // Mode register: locked outside the window, defaults on any reset
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            mode_reg <= MODE_RST; // [R08] [R16]
        end
        else if (rearm)
        begin
            mode_reg <= MODE_RST; // [R16]
        end
        else if (mode_wr)
        begin
            // Upper data bits are dropped, only five bits stored
            mode_reg <= wdtl_mode_t'(bus_req.wdata[4:0]); // [R13]
        end
    end

    // Write window: opens at first instruction, shuts after 122 clocks
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            win_wait_reg <= 1'b1;
            win_open_reg <= 1'b0;
            win_cnt_reg  <= 7'h00;
        end
        else if (rearm)
        begin
            win_wait_reg <= 1'b1;
            win_open_reg <= 1'b0;
            win_cnt_reg  <= 7'h00;
        end
        else if (win_wait_reg & first_instr)
        begin
            win_wait_reg <= 1'b0;
            win_open_reg <= 1'b1;
            win_cnt_reg  <= 7'h00;
        end
        else if (win_open_reg & xtal_tick)
        begin
            // Once shut it stays shut until the next reset
            win_open_reg <= ~win_last; // [R04]
            win_cnt_reg  <= win_cnt_reg + 7'h01;
        end
    end

    // Read data: one cycle after the strobe, zero otherwise
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            rd_data_reg <= 8'h00;
        end
        else if (bus_req.rd & hit_status)
        begin
            rd_data_reg <= status_word;
        end
        else
        begin
            // Mode location and unmapped addresses read zero
            rd_data_reg <= 8'h00; // [R05]
        end
    end

    // Stop exit pulse and restart address
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            stop_exit_reg    <= 1'b0;
            restart_addr_reg <= 16'h0000;
        end
        else
        begin
            stop_exit_reg <= timeout & stop_mode; // [R15]
            if (timeout & stop_mode)
            begin
                restart_addr_reg <= RESTART_VECTOR; // [R15]
            end
        end
    end

    // Condition flags written by each refresh instruction
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            flag_we_reg  <= 1'b0;
            flag_zsv_reg <= 3'h0;
        end
        else
        begin
            flag_we_reg <= wdt_instr; // [R03]
            if (wdt_instr)
            begin
                flag_zsv_reg <= FLAG_ZSV_VALUE; // [R03]
            end
        end
    end

    // Outputs
    assign rd_data      = rd_data_reg;
    assign proc_reset   = (state_reg == WDTL_HOLD); // [R14]
    assign stop_exit    = stop_exit_reg;
    assign restart_addr = restart_addr_reg;
    assign flag_we      = flag_we_reg;
    assign flag_zsv     = flag_zsv_reg;

    // Checks
    default clocking wdtl_cb @(posedge ref_clk);
    endclocking
    default disable iff (rst);

    AST_TIMEOUT_RESET: assert property (timeout |=> proc_reset && count_reg == 12'h000) // [R01]
        else $error("timeout did not raise processor reset");
    AST_ARM: assert property ((state_reg == WDTL_IDLE) && !wdt_instr |=> state_reg != WDTL_RUN) // [R02]
        else $error("watchdog armed without instruction");
    AST_REFRESH: assert property ((state_reg != WDTL_HOLD) && wdt_instr |=> count_reg == 12'h000) // [R02]
        else $error("refresh did not clear counter");
    AST_FLAGS: assert property (wdt_instr |=> flag_we && flag_zsv == FLAG_ZSV_VALUE) // [R03]
        else $error("flags not updated by refresh");
    AST_LOCK: assert property (bus_req.wr && hit_mode && !win_open_reg && !rearm |=> $stable(mode_reg)) // [R04]
        else $error("mode changed outside write window");
    AST_WIN_CLOSE: assert property (win_open_reg && win_last && !rearm |=> !win_open_reg) // [R04]
        else $error("write window not closed at limit");
    AST_READ_ZERO: assert property (bus_req.rd && hit_mode |=> rd_data == 8'h00) // [R05]
        else $error("mode register readable");
    AST_TERM_BOUND: assert property ((state_reg == WDTL_RUN) |-> count_reg <= term_m1) // [R07]
        else $error("counter passed terminal count");
    AST_HALT_HOLD: assert property ((state_reg == WDTL_RUN) && halt_mode && !mode_reg.halt_run
                                    && !wdt_instr |=> $stable(count_reg)) // [R09]
        else $error("counter ran in suspended halt");
    AST_STOP_HOLD: assert property ((state_reg == WDTL_RUN) && stop_mode && !mode_reg.stop_run
                                    && !wdt_instr |=> $stable(count_reg)) // [R10]
        else $error("counter ran in suspended stop");
    AST_HOLD_MIN: assert property ($rose(proc_reset) |-> proc_reset[*2]) // [R14]
        else $error("reset pulse too short");
    AST_STOP_EXIT: assert property (timeout && stop_mode |=> stop_exit && restart_addr == RESTART_VECTOR) // [R15]
        else $error("stop timeout without restart");
    AST_DEFAULTS: assert property ($fell(proc_reset) |-> mode_reg == MODE_RST && state_reg == WDTL_IDLE) // [R16]
        else $error("mode not defaulted after reset");

    COV_TIMEOUT: cover property (timeout);
    COV_MODE_WRITE: cover property (mode_wr ##1 !win_open_reg);
    COV_STOP_EXIT: cover property (stop_exit);
    COV_REARM: cover property ($fell(proc_reset) ##[1:8] first_instr);

endmodule : wdtl_watchdog
`default_nettype wire

// >>> tb/wdtl_watchdog_tb.sv
`timescale 1ns/10ps
`default_nettype none

// One compare: counts it, reports a mismatch at once
`define CHK(a, e) begin cmp_count++; if ((a) !== (e)) begin fail_count++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (a), (e)); end end

module wdtl_watchdog_tb;
    import wdtl_pkg::*;

    localparam int HOLD = 16;            // Short one-shot so the run stays brief

    logic        ref_clk;                // 250 MHz bench clock
    logic        rst;                    // Async reset, active high
    wdtl_req_t   bus_req;                // Register port request
    logic [7:0]  rd_data;                // Read data, cycle after rd
    logic        wdt_instr;              // Watchdog instruction executed
    logic        first_instr;            // First instruction after a reset
    logic        halt_mode;              // CPU halted
    logic        stop_mode;              // CPU stopped
    logic        stop_recovery;          // Stop recovery reset pulse
    logic        crystal_input_pin;      // Crystal ticks
    logic        rc_osc_pin;             // RC ticks
    logic        proc_reset;             // Processor held in reset
    logic        stop_exit;              // Timeout seen in stop
    logic [15:0] restart_addr;           // Restart vector
    logic        flag_we;                // Flag update strobe
    logic [2:0]  flag_zsv;               // Zero, sign, overflow
    int          fail_count;             // Mismatches
    int          cmp_count;              // Compares made
    int          hold_cnt;               // Cycles with proc_reset high
    int          exit_cnt;               // Cycles with stop_exit high

    wdtl_watchdog #(.POR_HOLD_CYCLES(HOLD)) u_wdtl_watchdog (
        .ref_clk(ref_clk), .rst(rst), .bus_req(bus_req), .rd_data(rd_data),
        .wdt_instr(wdt_instr), .first_instr(first_instr), .halt_mode(halt_mode),
        .stop_mode(stop_mode), .stop_recovery(stop_recovery),
        .crystal_input_pin(crystal_input_pin), .rc_osc_pin(rc_osc_pin),
        .proc_reset(proc_reset), .stop_exit(stop_exit), .restart_addr(restart_addr),
        .flag_we(flag_we), .flag_zsv(flag_zsv)
    );

    // Clock: 4 ns period
    initial ref_clk = 1'b0;
    always #2 ref_clk = ~ref_clk;

    // Count outputs per cycle; sampled before the edge's own updates land
    always @(posedge ref_clk)
    begin
        if (proc_reset === 1'b1) hold_cnt++;
        if (stop_exit === 1'b1) exit_cnt++;
    end

    // Verdict and end of run
    task automatic close_out;
        $display("compares %0d mismatches %0d", cmp_count, fail_count);
        if (fail_count == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out

    // One-cycle write into bank F
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge ref_clk) bus_req <= '{4'hf, a, d, 1'b1, 1'b0};
        @(posedge ref_clk) bus_req <= '0;
    endtask : wr

    // One-cycle read; data looked at only in the following cycle
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge ref_clk) bus_req <= '{4'hf, a, 8'h00, 1'b0, 1'b1};
        @(posedge ref_clk) bus_req <= '0;
        #1 `CHK(rd_data, e)
    endtask : rd

    // Watchdog instruction; the flag strobe must follow in the next cycle
    task automatic refresh;
        @(posedge ref_clk) wdt_instr <= 1'b1;
        @(posedge ref_clk) wdt_instr <= 1'b0;
        #1 `CHK({flag_we, flag_zsv}, {1'b1, FLAG_ZSV_VALUE})
    endtask : refresh

    // n rising edges on one oscillator pin, held two cycles so the synchroniser sees them
    task automatic tick(input bit xtal, input int n);
        repeat (n)
        begin
            @(posedge ref_clk)
            begin
                if (xtal) crystal_input_pin <= 1'b1;
                else rc_osc_pin <= 1'b1;
            end
            @(posedge ref_clk);
            @(posedge ref_clk)
            begin
                crystal_input_pin <= 1'b0;
                rc_osc_pin <= 1'b0;
            end
            @(posedge ref_clk);
        end
    endtask : tick

    // One short of terminal count nothing happens; the last tick starts the hold
    task automatic run_to(input bit xtal, input int n);
        hold_cnt = 0;
        tick(xtal, n - 1);
        repeat (8) @(posedge ref_clk);
        `CHK(hold_cnt, 0)
        tick(xtal, 1);
        repeat (HOLD + 12) @(posedge ref_clk);
        `CHK(hold_cnt, HOLD)
    endtask : run_to

    // Hang guard, well past the expected run of about 9.3k cycles
    initial
    begin
        #200000;
        fail_count++;
        close_out;
    end

    // Main sequence
    initial
    begin
        fail_count = 0;
        cmp_count = 0;
        hold_cnt = 0;
        exit_cnt = 0;
        rst = 1'b1;
        bus_req = '0;
        {wdt_instr, first_instr, halt_mode, stop_mode, stop_recovery} = '0;
        crystal_input_pin = 1'b0;
        rc_osc_pin = 1'b0;
        repeat (12) @(posedge ref_clk);
        rst <= 1'b0;
        // Out of reset: idle, window waiting, nothing driven
        rd(MODE_OFFSET - 8'h01, 8'h04);
        rd(MODE_OFFSET, 8'h00);
        rd(8'h33, 8'h00);
        `CHK({proc_reset, restart_addr}, 17'h0)
        // Unarmed counter ignores oscillator ticks
        hold_cnt = 0;
        tick(1'b0, 600);
        `CHK(hold_cnt, 0)
        // Default tap 512 on the RC source, in stop: crystal is dead there, so RC it is
        refresh();
        exit_cnt = 0;
        @(posedge ref_clk) stop_mode <= 1'b1;
        run_to(1'b0, 512);
        @(posedge ref_clk) stop_mode <= 1'b0;
        `CHK(exit_cnt, 1)
        `CHK(restart_addr, RESTART_VECTOR)
        rd(MODE_OFFSET - 8'h01, 8'h04);
        // Window: last write before the 122nd crystal tick is taken
        @(posedge ref_clk) first_instr <= 1'b1;
        @(posedge ref_clk) first_instr <= 1'b0;
        tick(1'b1, 121);
        wr(MODE_OFFSET, 8'hf8);
        rd(MODE_OFFSET - 8'h01, 8'h12);
        rd(MODE_OFFSET, 8'h00);
        tick(1'b1, 1);
        repeat (6) @(posedge ref_clk);
        rd(MODE_OFFSET - 8'h01, 8'h10);
        wr(MODE_OFFSET, 8'h07);
        rd(MODE_OFFSET - 8'h01, 8'h10);
        // Halt suspends counting, RC ticks unused on crystal source
        hold_cnt = 0;
        @(posedge ref_clk) halt_mode <= 1'b1;
        refresh();
        tick(1'b1, 300);
        halt_mode <= 1'b0;
        tick(1'b0, 300);
        `CHK(hold_cnt, 0)
        // Refresh mid-count restarts; tap 256 on crystal, no stop exit outside stop
        tick(1'b1, 200);
        refresh();
        exit_cnt = 0;
        run_to(1'b1, 256);
        `CHK(exit_cnt, 0)
        `CHK(restart_addr, RESTART_VECTOR)
        // Stop recovery re-arms the window and defaults a freshly written mode
        @(posedge ref_clk) first_instr <= 1'b1;
        @(posedge ref_clk) first_instr <= 1'b0;
        wr(MODE_OFFSET, 8'h10);
        rd(MODE_OFFSET - 8'h01, 8'h12);
        @(posedge ref_clk) stop_recovery <= 1'b1;
        @(posedge ref_clk) stop_recovery <= 1'b0;
        rd(MODE_OFFSET - 8'h01, 8'h04);
        close_out;
    end

endmodule : wdtl_watchdog_tb
`default_nettype wire
